// [pkg/bcsr_pkg.sv]
// Constants, field layouts and types shared by the boost control and soft reset register block.
// Assumes command words arrive already framed as 16-bit words.
package bcsr_pkg;

    localparam int unsigned WORD_W        = 16;
    localparam int unsigned CH_COUNT      = 4;

    // Word layout
    localparam int unsigned KIND_LSB      = 13;
    localparam int unsigned CRC_EN_BIT    = 12;
    localparam int unsigned CODE_LSB      = 0;
    localparam int unsigned CODE_W        = 12;
    localparam int unsigned BOOST_LSB     = 0;
    localparam int unsigned BOOST_W       = 7;
    localparam int unsigned SLEW_EN_BIT   = 12;
    localparam int unsigned SLEW_CLK_LSB  = 3;
    localparam int unsigned SLEW_STEP_LSB = 0;

    localparam logic [11:0] RESET_CODE     = 12'h555;
    localparam logic [11:0] KEEPALIVE_CODE = 12'h195;

    typedef enum logic [2:0] {
        K_SLEW  = 3'b000,
        K_BOOST = 3'b011,
        K_SW    = 3'b100,
        K_OTHER = 3'b111
    } bcsr_kind_t;

    localparam logic [1:0] PH_SAME  = 2'h0;
    localparam logic [1:0] PH_AB_CD = 2'h1;
    localparam logic [1:0] PH_AC_BD = 2'h2;
    localparam logic [1:0] PH_QUAD  = 2'h3;

    localparam logic [1:0] RATE_250 = 2'h0;
    localparam logic [1:0] RATE_410 = 2'h1;
    localparam logic [1:0] RATE_650 = 2'h2;

    // Switching rates and their periods in clock cycles
    localparam int unsigned MCLK_HZ     = 100_000_000;
    localparam int unsigned RATE_250_HZ = 250_000;
    localparam int unsigned RATE_410_HZ = 410_000;
    localparam int unsigned RATE_650_HZ = 650_000;
    localparam logic [15:0] PER_250     = 16'(MCLK_HZ / RATE_250_HZ);
    localparam logic [15:0] PER_410     = 16'(MCLK_HZ / RATE_410_HZ);
    localparam logic [15:0] PER_650     = 16'(MCLK_HZ / RATE_650_HZ);

    typedef struct packed {
        logic       comp_resistor_bypass;
        logic [1:0] converter_phase_select;
        logic [1:0] switching_rate_select;
        logic [1:0] boost_ceiling_select;
    } bcsr_boost_t;

    typedef struct packed {
        logic       slew_limit_enable;
        logic [3:0] clk_sel;
        logic [2:0] step_sel;
    } bcsr_slew_t;

    localparam logic        DEF_CRC_EN = 1'b0;
    localparam bcsr_boost_t DEF_BOOST  = '{comp_resistor_bypass: 1'b0, converter_phase_select: PH_SAME,
                                           switching_rate_select: RATE_410, boost_ceiling_select: 2'h0};
    localparam bcsr_slew_t  DEF_SLEW   = '{slew_limit_enable: 1'b0, clk_sel: 4'h0, step_sel: 3'h0};

endpackage

// [logic/bcsr_phase_gen.sv]
// Four-channel converter clock generator with selectable rate and inter-channel phase.
// Assumes phase and rate selects come from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module bcsr_phase_gen (
    input  wire logic                      mclk_i,
    input  wire logic                      arst_n_i,
    input  wire logic [1:0]                phase_i,
    input  wire logic [1:0]                rate_i,
    output logic [bcsr_pkg::CH_COUNT-1:0]  conv_clk_o
);
    import bcsr_pkg::*;

    function automatic logic [15:0] period_of(input logic [1:0] rate);
        case (rate)
            RATE_250: period_of = PER_250;
            RATE_650: period_of = PER_650;
            default:  period_of = PER_410;
        endcase
    endfunction

    // Offset of one channel within the period, in cycles
    function automatic logic [15:0] offset_of(input logic [1:0] ph, input int unsigned ch, input logic [15:0] per);
        logic [15:0] half;
        logic [15:0] quarter;
        half    = per >> 1;
        quarter = per >> 2;
        case (ph)
            PH_AB_CD: offset_of = (ch >= 2) ? half : 16'h0000;
            PH_AC_BD: offset_of = (ch == 1 || ch == 3) ? half : 16'h0000;
            PH_QUAD:  offset_of = 16'(quarter * 16'(ch));
            default:  offset_of = 16'h0000;
        endcase
    endfunction

    logic [15:0]         cnt_reg;
    logic [15:0]         cnt_next;
    logic [15:0]         per;
    logic [CH_COUNT-1:0] clk_reg;
    logic [CH_COUNT-1:0] clk_next;

    always_comb begin
        per      = period_of(rate_i);
        cnt_next = (cnt_reg >= per - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
    end

    generate
        for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
            logic [16:0] shifted;
            always_comb begin
                shifted = {1'b0, cnt_reg} + {1'b0, offset_of(phase_i, g, per)};
                if (shifted >= {1'b0, per}) begin
                    shifted = shifted - {1'b0, per};
                end
                clk_next[g] = (shifted[15:0] < (per >> 1));
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 16'h0000;
            clk_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
        end
    end

    assign conv_clk_o = clk_reg;

    a_phase_same: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $past(phase_i) == PH_SAME |-> (&clk_reg || ~|clk_reg))
        else $error("channels not on the same edge");
    a_phase_pairs: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $past(phase_i) == PH_AC_BD |-> (clk_reg[0] == clk_reg[2] && clk_reg[1] == clk_reg[3]))
        else $error("A/C or B/D pair not aligned");
    a_phase_quad: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $past(phase_i) == PH_QUAD && $past(phase_i, 2) == PH_QUAD |-> $countones(clk_reg) inside {1, 2, 3})
        else $error("quadrature channels coincide");
    a_rate_period: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $past(rate_i) == rate_i && $past(rate_i, 2) == rate_i |-> cnt_reg < period_of(rate_i))
        else $error("switching period exceeds selected rate");

endmodule // bcsr_phase_gen
`default_nettype wire

// [logic/bcsr_regs.sv]
// Boost converter control and software command register block with watchdog keep-alive.
// Assumes each command word arrives framed and checked, with a one-cycle valid strobe.
//
// Notes on behaviour
// - Software command word bit 12 sets the checksum enable, except in the reset command, which clears it.
// - Low twelve bits 0x555 in a software command reset the whole block except the converter clock generator counter and clock output registers.
// - Missing keep-alive within timeout raises the fault alert output.
// - Bit 6 of boost word: 0 internal compensation resistor, 1 bypass.
// - Phase codes 00 same edge, 01 AB vs CD, 10 AC vs BD.
// - Phase code 11 spaces the four converter clocks a quarter period apart.
// - Rate field picks 250, 410 (default) or 650 kHz switching.
// - Two-bit ceiling field selects boost voltage code, default 00.
// - Slew limiting enable and settings are stored separately per channel.
`timescale 1ns/1ps
`default_nettype none
module bcsr_regs #(
    parameter int unsigned WDT_TIMEOUT_CYCLES = 100_000
) (
    input  wire logic                               mclk_i,
    input  wire logic                               arst_n_i,
    input  wire logic                               word_valid_i,
    input  wire logic [bcsr_pkg::WORD_W-1:0]        word_i,
    input  wire logic [1:0]                         slew_chan_i,
    input  wire logic                               wdt_enable_i,
    output logic                                    crc_check_enable_o,
    output var bcsr_pkg::bcsr_boost_t               boost_cfg_o,
    output var bcsr_pkg::bcsr_slew_t [bcsr_pkg::CH_COUNT-1:0] slew_cfg_o,
    output logic                                    soft_reset_o,
    output logic                                    fault_alert_o,
    output logic [bcsr_pkg::CH_COUNT-1:0]           conv_clk_o
);
    import bcsr_pkg::*;

    localparam logic [31:0] WDT_LAST = 32'(WDT_TIMEOUT_CYCLES - 1);

    function automatic bcsr_kind_t word_kind(input logic [WORD_W-1:0] w);
        case (w[KIND_LSB +: 3])
            K_SW:    word_kind = K_SW;
            K_BOOST: word_kind = K_BOOST;
            K_SLEW:  word_kind = K_SLEW;
            default: word_kind = K_OTHER;
        endcase
    endfunction

    bcsr_kind_t  kind;
    logic [11:0] code;
    logic        is_reset;
    logic        is_kick;

    logic        crc_en_reg;
    logic        crc_en_next;
    bcsr_boost_t boost_reg;
    bcsr_boost_t boost_next;
    logic        srst_reg;
    logic        srst_next;
    logic [31:0] wdt_cnt_reg;
    logic [31:0] wdt_cnt_next;
    logic        alert_reg;
    logic        alert_next;

    always_comb begin
        kind     = word_kind(word_i);
        code     = word_i[CODE_LSB +: CODE_W];
        is_reset = word_valid_i && kind == K_SW && code == RESET_CODE;
        is_kick  = word_valid_i && kind == K_SW && code == KEEPALIVE_CODE;
    end

    // Command decode and configuration registers
    always_comb begin
        crc_en_next = crc_en_reg;
        boost_next  = boost_reg;
        srst_next   = 1'b0;
        if (is_reset) begin
            crc_en_next = DEF_CRC_EN;
            boost_next  = DEF_BOOST;
            srst_next   = 1'b1;
        end else if (word_valid_i) begin
            case (kind)
                K_SW:    crc_en_next = word_i[CRC_EN_BIT];
                K_BOOST: boost_next  = bcsr_boost_t'(word_i[BOOST_LSB +: BOOST_W]);
                default: crc_en_next = crc_en_reg;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crc_en_reg <= DEF_CRC_EN;
            boost_reg  <= DEF_BOOST;
            srst_reg   <= 1'b0;
        end else begin
            crc_en_reg <= crc_en_next;
            boost_reg  <= boost_next;
            srst_reg   <= srst_next;
        end
    end

    // Watchdog: expiry sets the alert, a keep-alive restarts the count and clears the alert unless the count has stalled at expiry
    always_comb begin
        wdt_cnt_next = wdt_cnt_reg;
        alert_next   = alert_reg;
        if (!wdt_enable_i || is_reset) begin
            wdt_cnt_next = 32'h0000_0000;
            alert_next   = 1'b0;
        end else if (wdt_cnt_reg == WDT_LAST) begin
            // Stalled here, a keep-alive restarts the count but the alert stays set
            alert_next   = 1'b1;
            wdt_cnt_next = is_kick ? 32'h0000_0000 : wdt_cnt_reg;
        end else if (is_kick) begin
            wdt_cnt_next = 32'h0000_0000;
            alert_next   = 1'b0;
        end else begin
            wdt_cnt_next = wdt_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wdt_cnt_reg <= 32'h0000_0000;
            alert_reg   <= 1'b0;
        end else begin
            wdt_cnt_reg <= wdt_cnt_next;
            alert_reg   <= alert_next;
        end
    end

    // Per-channel slew limit settings
    generate
        for (genvar g = 0; g < CH_COUNT; g++) begin : g_slew
            bcsr_slew_t slew_reg;
            bcsr_slew_t slew_next;
            always_comb begin
                slew_next = slew_reg;
                if (is_reset) begin
                    slew_next = DEF_SLEW;
                end else if (word_valid_i && kind == K_SLEW && slew_chan_i == 2'(g)) begin
                    slew_next.slew_limit_enable = word_i[SLEW_EN_BIT];
                    slew_next.clk_sel           = word_i[SLEW_CLK_LSB +: 4];
                    slew_next.step_sel          = word_i[SLEW_STEP_LSB +: 3];
                end
            end
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    slew_reg <= DEF_SLEW;
                end else begin
                    slew_reg <= slew_next;
                end
            end
            assign slew_cfg_o[g] = slew_reg;

            a_slew_load: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
                word_valid_i && word_kind(word_i) == K_SLEW && slew_chan_i == 2'(g)
                |=> slew_cfg_o[g] == {$past(word_i[SLEW_EN_BIT]), $past(word_i[6:0])})
                else $error("slew settings not stored for channel");
            a_slew_isolate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
                word_valid_i && word_kind(word_i) == K_SLEW && slew_chan_i != 2'(g) |=> $stable(slew_cfg_o[g]))
                else $error("slew write leaked to another channel");
        end
    endgenerate

    bcsr_phase_gen u_phase (
        .mclk_i     (mclk_i),
        .arst_n_i   (arst_n_i),
        .phase_i    (boost_reg.converter_phase_select),
        .rate_i     (boost_reg.switching_rate_select),
        .conv_clk_o (conv_clk_o)
    );

    assign crc_check_enable_o = crc_en_reg;
    assign boost_cfg_o        = boost_reg;
    assign soft_reset_o       = srst_reg;
    assign fault_alert_o      = alert_reg;

    sequence s_plain_sw;
        word_valid_i && word_kind(word_i) == K_SW && word_i[11:0] != RESET_CODE;
    endsequence

    sequence s_reset_cmd;
        word_valid_i && word_kind(word_i) == K_SW && word_i[11:0] == RESET_CODE;
    endsequence

    a_crc_enable_load: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_plain_sw |=> crc_check_enable_o == $past(word_i[CRC_EN_BIT]))
        else $error("checksum enable not taken from bit 12");
    a_soft_reset_all: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_reset_cmd |=> soft_reset_o && !crc_check_enable_o && boost_cfg_o == DEF_BOOST && !fault_alert_o)
        else $error("reset code did not restore defaults");
    a_other_code_quiet: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_plain_sw |=> !soft_reset_o && $stable(boost_cfg_o) && $stable(slew_cfg_o))
        else $error("plain software command had side effects");
    a_boost_load: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        word_valid_i && word_kind(word_i) == K_BOOST |=> boost_cfg_o == $past(word_i[6:0]))
        else $error("boost control fields not stored");
    a_boost_route: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        word_valid_i && word_kind(word_i) != K_BOOST && !(word_kind(word_i) == K_SW && word_i[11:0] == RESET_CODE)
        |=> $stable(boost_cfg_o))
        else $error("boost control changed by another word");
    a_alert_timeout: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        wdt_enable_i && wdt_cnt_reg == WDT_LAST && !(word_valid_i && word_kind(word_i) == K_SW &&
        word_i[11:0] == RESET_CODE) |=> fault_alert_o)
        else $error("watchdog expiry did not raise alert");
    a_alert_kick: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        wdt_enable_i && wdt_cnt_reg != WDT_LAST && word_valid_i && word_kind(word_i) == K_SW &&
        word_i[11:0] == KEEPALIVE_CODE |=> !fault_alert_o [*2])
        else $error("keep-alive did not hold alert low");
    a_alert_disabled: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !wdt_enable_i |=> !fault_alert_o)
        else $error("alert raised while watchdog disabled");
    a_alert_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        fault_alert_o && wdt_enable_i && !(word_valid_i && word_kind(word_i) == K_SW &&
        (word_i[11:0] == KEEPALIVE_CODE || word_i[11:0] == RESET_CODE)) |=> fault_alert_o)
        else $error("alert dropped without keep-alive");
    a_srst_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !(word_valid_i && word_kind(word_i) == K_SW && word_i[11:0] == RESET_CODE) |=> !soft_reset_o)
        else $error("soft reset pulse without reset code");
    a_crc_route: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        word_valid_i && word_kind(word_i) != K_SW |=> $stable(crc_check_enable_o))
        else $error("checksum enable changed by another word");

endmodule // bcsr_regs
`default_nettype wire

// [bench/bcsr_host_model.sv]
// Host side model: presents framed command words one at a time.
// Assumes the block takes a word on the edge where valid is high.
`timescale 1ns/1ps
`default_nettype none
module bcsr_host_model (
    input  wire logic                        mclk_i,
    output logic                             word_valid_o,
    output logic [bcsr_pkg::WORD_W-1:0]      word_o,
    output logic [1:0]                       slew_chan_o
);
    import bcsr_pkg::*;

    initial begin
        word_valid_o = 1'b0;
        word_o       = 16'h0000;
        slew_chan_o  = 2'h0;
    end

    task automatic send_word(input logic [15:0] w, input logic [1:0] ch);
        @(posedge mclk_i);
        word_valid_o <= 1'b1;
        word_o       <= w;
        slew_chan_o  <= ch;
        @(posedge mclk_i);
        word_valid_o <= 1'b0;
        // Idle lines show no stale word
        word_o       <= ~w;
        slew_chan_o  <= ~ch;
    endtask

    task automatic kick(input logic crc_en);
        send_word({K_SW, crc_en, KEEPALIVE_CODE}, 2'h0);
    endtask
endmodule // bcsr_host_model
`default_nettype wire

// [bench/test_bcsr_regs.sv]
// Testbench for the boost control and soft reset register block.
// Assumes a short watchdog timeout and the host model as word source.
`timescale 1ns/1ps
`default_nettype none
module test_bcsr_regs;
    import bcsr_pkg::*;
    localparam int unsigned T = 16;

    logic                          mclk_i;
    logic                          arst_n_i;
    logic                          word_valid_i;
    logic [WORD_W-1:0]             word_i;
    logic [1:0]                    slew_chan_i;
    logic                          wdt_enable_i;
    logic                          crc_check_enable_o;
    bcsr_boost_t                   boost_cfg_o;
    bcsr_slew_t [CH_COUNT-1:0]     slew_cfg_o;
    logic                          soft_reset_o;
    logic                          fault_alert_o;
    logic [CH_COUNT-1:0]           conv_clk_o;
    int                            n_errors;
    int                            cmp_count;
    logic [6:0]                    bt [5] = '{7'h00, 7'h15, 7'h2a, 7'h7f, 7'h40};

    bcsr_host_model host (
        .mclk_i       (mclk_i),
        .word_valid_o (word_valid_i),
        .word_o       (word_i),
        .slew_chan_o  (slew_chan_i)
    );

    bcsr_regs #(.WDT_TIMEOUT_CYCLES(T)) dut (
        .mclk_i             (mclk_i),
        .arst_n_i           (arst_n_i),
        .word_valid_i       (word_valid_i),
        .word_i             (word_i),
        .slew_chan_i        (slew_chan_i),
        .wdt_enable_i       (wdt_enable_i),
        .crc_check_enable_o (crc_check_enable_o),
        .boost_cfg_o        (boost_cfg_o),
        .slew_cfg_o         (slew_cfg_o),
        .soft_reset_o       (soft_reset_o),
        .fault_alert_o      (fault_alert_o),
        .conv_clk_o         (conv_clk_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // Measures channel A period and each channel's rise offset from A
    task automatic phase_chk(input logic [1:0] p, input logic [1:0] r, input int per);
        int t[4];
        int off;
        int c;
        logic [3:0] pv;
        host.send_word({K_BOOST, 6'h00, 1'b0, p, r, 2'h0}, 2'h0);
        repeat (per + 4) tick();
        t = '{default: -1};
        c = 0;
        do begin
            pv = conv_clk_o;
            tick();
            c++;
        end while (c < per + 2 && !(conv_clk_o[0] === 1'b1 && pv[0] === 1'b0));
        for (c = 0; c <= per + 1; c++) begin
            for (int k = 0; k < 4; k++) begin
                if (t[k] < 0 && (c > 0 || k > 0) && conv_clk_o[k] === 1'b1 && pv[k] === 1'b0) begin
                    t[k] = c;
                end
            end
            pv = conv_clk_o;
            tick();
        end
        chk("period", 32'(per), 32'(t[0]));
        for (int k = 1; k < 4; k++) begin
            off = (p == 2'h1) ? ((k >= 2) ? per / 2 : 0) :
                  (p == 2'h2) ? ((k % 2) ? per / 2 : 0) :
                  (p == 2'h3) ? k * (per / 4) : 0;
            if (t[k] == (per - off) % per) begin
                off = (per - off) % per;
            end
            chk("offset", 32'(off), 32'(t[k]));
        end
    endtask

    initial begin
        #500us;
        n_errors++;
        $display("BAD watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        n_errors     = 0;
        cmp_count    = 0;
        arst_n_i     = 1'b0;
        wdt_enable_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        #1;
        chk("crc_rst", 32'h0, 32'(crc_check_enable_o));
        chk("boost_rst", 32'h4, 32'(boost_cfg_o));
        chk("slew_rst", 32'h0, 32'(slew_cfg_o));
        host.send_word(16'h9000, 2'h0);
        #1;
        chk("crc_on", 32'h1, 32'(crc_check_enable_o));
        chk("srst_other", 32'h0, 32'(soft_reset_o));
        chk("boost_other", 32'h4, 32'(boost_cfg_o));
        host.send_word(16'h8aaa, 2'h0);
        #1;
        chk("crc_off", 32'h0, 32'(crc_check_enable_o));
        foreach (bt[i]) begin
            host.send_word({K_BOOST, 6'h3f, bt[i]}, 2'h0);
            #1;
            chk("boost", 32'(bt[i]), 32'(boost_cfg_o));
        end
        host.send_word(16'he07f, 2'h0);
        #1;
        chk("boost_kind", 32'h40, 32'(boost_cfg_o));
        for (int k = 0; k < 4; k++) begin
            host.send_word({3'b000, 1'b1, 5'h1f, 4'(k + 5), 3'(k)}, 2'(k));
        end
        #1;
        for (int k = 0; k < 4; k++) begin
            chk("slew", 32'({1'b1, 4'(k + 5), 3'(k)}), 32'(slew_cfg_o[k]));
        end
        for (int p = 0; p < 4; p++) begin
            phase_chk(2'(p), 2'h1, 243);
        end
        phase_chk(2'h0, 2'h0, 400);
        phase_chk(2'h0, 2'h2, 153);
        host.send_word(16'h9000, 2'h0);
        host.send_word(16'h607f, 2'h0);
        host.send_word(16'h9555, 2'h0);
        #1;
        chk("srst", 32'h1, 32'(soft_reset_o));
        chk("srst_crc", 32'h0, 32'(crc_check_enable_o));
        chk("srst_boost", 32'h4, 32'(boost_cfg_o));
        chk("srst_slew", 32'h0, 32'(slew_cfg_o));
        tick();
        chk("srst_end", 32'h0, 32'(soft_reset_o));
        @(posedge mclk_i);
        wdt_enable_i <= 1'b1;
        repeat (4) begin
            repeat (T / 2) tick();
            host.kick(1'b0);
        end
        repeat (T - 1) tick();
        chk("alert_kept", 32'h0, 32'(fault_alert_o));
        tick();
        chk("alert_set", 32'h1, 32'(fault_alert_o));
        repeat (2) tick();
        // The count stalls at its last value, so the first kick only restarts it
        host.kick(1'b1);
        #1;
        chk("alert_stall", 32'h1, 32'(fault_alert_o));
        host.kick(1'b1);
        #1;
        chk("alert_kick", 32'h0, 32'(fault_alert_o));
        chk("crc_kick", 32'h1, 32'(crc_check_enable_o));
        repeat (T + 4) tick();
        chk("alert_again", 32'h1, 32'(fault_alert_o));
        @(posedge mclk_i);
        wdt_enable_i <= 1'b0;
        tick();
        chk("alert_dis", 32'h0, 32'(fault_alert_o));
        end_of_test();
    end
endmodule // test_bcsr_regs
`default_nettype wire
